// file: phs_pkg.sv
`default_nettype none
package phs_pkg;
  // ****************************************************************
  // Register word addresses (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_ACC_LOW = 8'h00;
  localparam logic [7:0] ADDR_ACC_HIGH = 8'h04;
  localparam logic [7:0] ADDR_ACC_UPPER = 8'h08;
  localparam logic [7:0] ADDR_INC_LOW = 8'h0C;
  localparam logic [7:0] ADDR_INC_HIGH = 8'h10;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam logic [ACC_W-1:0] ACC_RESET = 20'h0_0000;
  localparam logic [7:0] INC_LOW_RESET = 8'h01;
  localparam logic [7:0] INC_HIGH_RESET = 8'h00;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OE_BIT = 6;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PFM_BIT = 0;
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;

  // Clock source selection codes
  typedef enum logic [1:0] {
    CKS_FAST_OSC = 2'b00,
    CKS_SYSTEM = 2'b01,
    CKS_LOGIC_CELL = 2'b10,
    CKS_EXT_PIN = 2'b11
  } phs_cks_type;
endpackage
`default_nettype wire

// file: phs_osc.sv
// Notes on behaviour
// - Twenty-bit accumulator read and written as three byte registers.
// - Upper accumulator byte bits 7 to 4 read zero, writes ignored.
// - Sixteen-bit phase increment writable as low and high bytes; the high byte reads back from its hold register.
// - Increment resets to one: only low byte bit 0 set.
// - Accumulator resets to zero after every reset source.
// - Polarity bit set inverts output; clear passes it unchanged.
// - Pulse mode pulse lasts two to the code oscillator clock periods.
// - Clock field selects fast oscillator, system clock, logic cell, pin.
// - Oscillator runs from its own source, independent of CPU sleep.
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module phs_osc (
  input wire logic clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic fast_osc_i, // Fast internal oscillator
  input wire logic logic_cell_i, // Logic cell output
  input wire logic ext_clk_i, // External clock pin
  output logic out_o, // Oscillator output after polarity
  output logic out_oe_o // Output pin enable
);
  localparam int NSRC = 3;

  logic [phs_pkg::ACC_W-1:0] acc;
  logic [7:0] inc_low;
  logic [7:0] inc_high;
  logic [7:0] inc_high_hold;
  logic en;
  logic oe;
  logic pol;
  logic pfm;
  logic [2:0] pws;
  logic [1:0] cks;
  logic raw;
  logic [7:0] pulse_cnt;
  logic [NSRC-1:0] src_pin;
  logic [NSRC-1:0] src_edge;
  logic tick;
  logic ovf;
  logic [phs_pkg::ACC_W:0] sum;
  logic req;
  logic wr;
  logic [31:0] next_dat;
  logic acc_wr;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];
  assign src_pin = {ext_clk_i, logic_cell_i, fast_osc_i};

  // ****************************************************************
  // Clock source synchronisers
  // ****************************************************************
  // Three stages; an edge counts once stages two and three agree high
  // after a settled low, so a glitch caught by stage one is ignored.
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    logic s1;
    logic s2;
    logic s3;
    logic settled;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        settled <= 1'b0;
      end else begin
        s1 <= src_pin[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          settled <= s3;
        end
      end
    end
    assign src_edge[g] = s2 & s3 & ~settled;
  end

  // ****************************************************************
  // Tick selection and accumulator sum
  // ****************************************************************
  // source select decode
  // tick comes only from the chosen source, not from CPU state
  always_comb begin
    case (phs_pkg::phs_cks_type'(cks))
      phs_pkg::CKS_FAST_OSC: tick = src_edge[0];
      phs_pkg::CKS_SYSTEM: tick = 1'b1;
      phs_pkg::CKS_LOGIC_CELL: tick = src_edge[1];
      default: tick = src_edge[2];
    endcase
  end

  assign sum = {1'b0, acc} + {5'h0_0, inc_high, inc_low};
  assign ovf = en & tick & sum[phs_pkg::ACC_W];
  assign acc_wr = wr & ((adr_i == phs_pkg::ADDR_ACC_LOW) |
                        (adr_i == phs_pkg::ADDR_ACC_HIGH) |
                        (adr_i == phs_pkg::ADDR_ACC_UPPER));

  // ****************************************************************
  // Phase accumulator
  // ****************************************************************
  // Software write wins over the running add in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= phs_pkg::ACC_RESET;
    end else if (wr && adr_i == phs_pkg::ADDR_ACC_LOW) begin
      acc[7:0] <= dat_i[7:0];
    end else if (wr && adr_i == phs_pkg::ADDR_ACC_HIGH) begin
      acc[15:8] <= dat_i[7:0];
    end else if (wr && adr_i == phs_pkg::ADDR_ACC_UPPER) begin
      // bits 7 to 4 of the data are dropped
      acc[19:16] <= dat_i[3:0];
    end else if (en && tick) begin
      acc <= sum[phs_pkg::ACC_W-1:0];
    end
  end

  // ****************************************************************
  // Phase increment
  // ****************************************************************
  // High byte waits in a hold register and both bytes take effect on
  // the low-byte write, so the adder never sees a half-updated value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_low <= phs_pkg::INC_LOW_RESET;
      inc_high <= phs_pkg::INC_HIGH_RESET;
      inc_high_hold <= phs_pkg::INC_HIGH_RESET;
    end else if (wr && adr_i == phs_pkg::ADDR_INC_HIGH) begin
      // high byte first, held until low byte
      inc_high_hold <= dat_i[7:0];
    end else if (wr && adr_i == phs_pkg::ADDR_INC_LOW) begin
      // low write commits the full value
      inc_low <= dat_i[7:0];
      inc_high <= inc_high_hold;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en <= 1'b0;
      oe <= 1'b0;
      pol <= 1'b0;
      pfm <= 1'b0;
      pws <= 3'h0;
      cks <= 2'h0;
    end else if (wr && adr_i == phs_pkg::ADDR_CTRL) begin
      en <= dat_i[phs_pkg::CTRL_EN_BIT];
      oe <= dat_i[phs_pkg::CTRL_OE_BIT];
      pol <= dat_i[phs_pkg::CTRL_POL_BIT];
      pfm <= dat_i[phs_pkg::CTRL_PFM_BIT];
    end else if (wr && adr_i == phs_pkg::ADDR_CLK_CTRL) begin
      pws <= dat_i[phs_pkg::CLK_PWS_LSB +: 3];
      cks <= dat_i[phs_pkg::CLK_CKS_LSB +: 2];
    end
  end

  // ****************************************************************
  // Output waveform
  // ****************************************************************
  // A pulse longer than the overflow period restarts on each overflow.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      raw <= 1'b0;
      pulse_cnt <= 8'h00;
    end else if (ovf && !pfm) begin
      raw <= ~raw;
    end else if (ovf) begin
      // pulse lasts two to the code ticks
      raw <= 1'b1;
      pulse_cnt <= 8'((9'h001 << pws) - 9'h001);
    end else if (pfm && raw && tick) begin
      if (pulse_cnt == 8'h00) begin
        raw <= 1'b0;
      end else begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
    end
  end

  // polarity applied at the output
  // Registered so the pin never shows the XOR settling; costs one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
    end else begin
      out_o <= raw ^ pol;
    end
  end
  assign out_oe_o = oe;

  // ****************************************************************
  // Wishbone read path and acknowledge
  // ****************************************************************
  // Unmapped addresses read zero; writes to them are dropped.
  always_comb begin
    next_dat = 32'h0000_0000;
    if (adr_i == phs_pkg::ADDR_ACC_LOW) begin
      next_dat[7:0] = acc[7:0];
    end else if (adr_i == phs_pkg::ADDR_ACC_HIGH) begin
      next_dat[7:0] = acc[15:8];
    end else if (adr_i == phs_pkg::ADDR_ACC_UPPER) begin
      next_dat[3:0] = acc[19:16];
    end else if (adr_i == phs_pkg::ADDR_INC_LOW) begin
      next_dat[7:0] = inc_low;
    end else if (adr_i == phs_pkg::ADDR_INC_HIGH) begin
      next_dat[7:0] = inc_high_hold;
    end else if (adr_i == phs_pkg::ADDR_CLK_CTRL) begin
      next_dat[phs_pkg::CLK_PWS_LSB +: 3] = pws;
      next_dat[phs_pkg::CLK_CKS_LSB +: 2] = cks;
    end else if (adr_i == phs_pkg::ADDR_CTRL) begin
      next_dat[phs_pkg::CTRL_EN_BIT] = en;
      next_dat[phs_pkg::CTRL_OE_BIT] = oe;
      next_dat[phs_pkg::CTRL_OUT_BIT] = out_o;
      next_dat[phs_pkg::CTRL_POL_BIT] = pol;
      next_dat[phs_pkg::CTRL_PFM_BIT] = pfm;
    end
  end

  // One wait state: answer in the cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= req ? next_dat : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_upper_read_zero: assert property (
    req && !we_i && adr_i == phs_pkg::ADDR_ACC_UPPER |=> dat_o[7:4] == 4'h0)
    else $error("upper accumulator byte high nibble not zero");
  a_acc_add_step: assert property (
    en && tick && !acc_wr |=> acc == $past(sum[phs_pkg::ACC_W-1:0]))
    else $error("accumulator did not add increment");
  a_acc_hold_off: assert property (
    !en && !acc_wr |=> $stable(acc))
    else $error("accumulator moved while disabled");
  a_inc_reset_one: assert property (
    $fell(rst_i) |-> {inc_high, inc_low} == 16'h0001)
    else $error("increment not one after reset");
  a_acc_reset_zero: assert property (
    $fell(rst_i) |-> acc == phs_pkg::ACC_RESET)
    else $error("accumulator not zero after reset");
  a_inc_low_commit: assert property (
    wr && adr_i == phs_pkg::ADDR_INC_LOW
    |=> inc_high == $past(inc_high_hold) && inc_low == $past(dat_i[7:0]))
    else $error("increment commit wrong");
  a_pol_inverts: assert property (
    $changed(pol) && $stable(raw) |=> $changed(out_o))
    else $error("polarity change did not flip output");
  a_pulse_ends: assert property (
    en && pfm && raw && tick && pulse_cnt == 8'h00 && !ovf
    && !(wr && adr_i == phs_pkg::ADDR_CTRL) |=> !raw)
    else $error("pulse did not end on count");
  a_sys_tick: assert property (
    cks == phs_pkg::CKS_SYSTEM |-> tick)
    else $error("system clock source gave no tick");
  a_fixed_toggle: assert property (
    ovf && !pfm && !(wr && adr_i == phs_pkg::ADDR_CTRL)
    |=> raw != $past(raw))
    else $error("fixed duty output did not toggle");
  a_wb_ack: assert property (
    req |=> ack_o ##1 !ack_o)
    else $error("bus acknowledge timing wrong");
  a_idle_data_zero: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  a_inc_high_held: assert property (
    wr && adr_i == phs_pkg::ADDR_INC_HIGH |=> $stable(inc_high))
    else $error("increment high byte used before low byte write");
  a_src_single_tick: assert property (
    src_edge[2] |=> !src_edge[2])
    else $error("pin source edge lasted more than one cycle");

  c_overflow_fixed: cover property (ovf && !pfm);
  c_pulse_full: cover property (raw && pfm && pws == 3'h3 && tick);
  c_pin_source: cover property (cks == phs_pkg::CKS_EXT_PIN && tick && en);
  c_cell_source: cover property (cks == phs_pkg::CKS_LOGIC_CELL && tick && en);
  c_pulse_widest: cover property (pfm && ovf && pws == 3'h7);
endmodule
`default_nettype wire

// file: nco_accumulator_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nco_accumulator_registers_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic out_o;
  logic out_oe_o;
  logic [2:0] pins = 3'h0;
  logic [31:0] seed = 32'h0001_5550;
  int n_mismatch = 0;
  int samples_checked = 0;

  // 250 MHz system clock
  always #2 clk_i = ~clk_i;

  phs_osc u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .fast_osc_i(pins[0]),
    .logic_cell_i(pins[1]), .ext_clk_i(pins[2]), .out_o(out_o),
    .out_oe_o(out_oe_o)
  );

  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  function automatic logic [31:0] rst_val(input logic [7:0] a);
    if (a == phs_pkg::ADDR_INC_LOW) begin
      return {24'h00_0000, phs_pkg::INC_LOW_RESET};
    end
    return 32'h0000_0000;
  endfunction

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic s, output logic [31:0] r);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= {3'b000, s};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 20) begin
      n_mismatch++;
      $display("[ERR] %0t bus acknowledge timed out", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 1'b1, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, 1'b1, r);
    chk(r, e);
  endtask

  // Slow pulses so the three-flop synchroniser sees every edge
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      pins[p] <= 1'b1;
      repeat (4) @(posedge clk_i);
      pins[p] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  // Cycles until the output changes, bounded
  task automatic wait_chg(output int n);
    logic v;
    v = out_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (out_o === v && n < 1000);
    if (n >= 1000) begin
      n_mismatch++;
      $display("[ERR] %0t output change timed out", $time);
      conclude();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] cs [3];
    int i;
    int k;
    int n;
    cs = '{2'b00, 2'b10, 2'b11};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, plus one unmapped word at the end
    for (i = 0; i < 8; i++) begin
      rd(8'(i * 4), rst_val(8'(i * 4)));
    end
    // Random bytes; upper nibble of the top byte must read zero
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed;
      wr(phs_pkg::ADDR_ACC_LOW, d);
      wr(phs_pkg::ADDR_ACC_HIGH, d >> 8);
      wr(phs_pkg::ADDR_ACC_UPPER, d >> 16);
      wb(1'b1, phs_pkg::ADDR_ACC_LOW, ~d, 1'b0, d);
      d = seed;
      rd(phs_pkg::ADDR_ACC_LOW, {24'h00_0000, d[7:0]});
      rd(phs_pkg::ADDR_ACC_HIGH, {24'h00_0000, d[15:8]});
      rd(phs_pkg::ADDR_ACC_UPPER, {28'h000_0000, d[19:16]});
      wr(phs_pkg::ADDR_INC_HIGH, d >> 24);
      wr(phs_pkg::ADDR_INC_LOW, d >> 8);
      rd(phs_pkg::ADDR_INC_HIGH, {24'h00_0000, d[31:24]});
      rd(phs_pkg::ADDR_INC_LOW, {24'h00_0000, d[15:8]});
    end
    // Polarity with the oscillator stopped: raw output is low
    wr(phs_pkg::ADDR_CTRL, 32'h0000_0010);
    chk(out_o, 1);
    chk(out_oe_o, 0);
    wr(phs_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(out_o, 0);
    // Pin sources: only edges on the selected pin advance the phase
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      k = 1 + int'(seed[2:0]);
      d = {24'h00_0000, seed[15:8] | 8'h01};
      wr(phs_pkg::ADDR_ACC_LOW, 0);
      wr(phs_pkg::ADDR_ACC_HIGH, 0);
      wr(phs_pkg::ADDR_INC_HIGH, 0);
      wr(phs_pkg::ADDR_INC_LOW, d);
      wr(phs_pkg::ADDR_CLK_CTRL, {30'h000_0000, cs[i]});
      wr(phs_pkg::ADDR_CTRL, 32'h0000_0080);
      pulse((i + 1) % 3, 2);
      pulse(i, k);
      repeat (8) @(posedge clk_i);
      wr(phs_pkg::ADDR_CTRL, 0);
      rd(phs_pkg::ADDR_ACC_LOW, (d * k) & 32'h0000_00FF);
      rd(phs_pkg::ADDR_ACC_HIGH, ((d * k) >> 8) & 32'h0000_00FF);
    end
    // System clock, step 0x1000: overflow every 256 cycles
    wr(phs_pkg::ADDR_CLK_CTRL, 32'h0000_0001);
    wr(phs_pkg::ADDR_INC_HIGH, 32'h0000_0010);
    wr(phs_pkg::ADDR_INC_LOW, 0);
    wr(phs_pkg::ADDR_CTRL, 32'h0000_00C0);
    chk(out_oe_o, 1);
    wait_chg(n);
    wait_chg(n);
    chk(n, 256);
    // Pulse mode at every width code; period twice the widest width
    for (i = 0; i < 8; i++) begin
      wr(phs_pkg::ADDR_CTRL, 0);
      wr(phs_pkg::ADDR_CLK_CTRL, (i << 5) | 1);
      wr(phs_pkg::ADDR_CTRL, 32'h0000_0081);
      wait_chg(n);
      chk(out_o, 1);
      wait_chg(n);
      chk(n, 1 << i);
    end
    // Reset in mid-run, oscillator still enabled: state returns to reset
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 7; i++) begin
      rd(8'(i * 4), rst_val(8'(i * 4)));
    end
    chk(out_o, 0);
    conclude();
  end
endmodule
`default_nettype wire
